// ==== design/ext_pin_detect.sv ====
// External interrupt pin sampler: low-level or falling-edge detection.
// Assumes pins synchronous to ref_clk and a one-cycle sample enable.
`default_nettype none
module ext_pin_detect (
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    input  wire logic       sample_en,
    input  wire logic [1:0] pin_n,
    input  wire logic [1:0] ext_trigger_select,
    output logic      [1:0] pin_req
);
    typedef struct packed {
        logic [1:0] last;
        logic [1:0] req;
    } det_s;

    det_s s_q;
    det_s s_d;

    always_comb begin
        s_d = s_q;
        s_d.req = 2'h0;
        if (sample_en) begin
            for (int i = 0; i < 2; i++) begin
                if (ext_trigger_select[i]) begin
                    s_d.req[i] = s_q.last[i] & ~pin_n[i]; // [RQ12]
                end else begin
                    s_d.req[i] = ~pin_n[i]; // [RQ12]
                end
            end
            s_d.last = pin_n; // [RQ14]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            s_q <= '{last: 2'h3, req: 2'h0};
        end else begin
            s_q <= s_d;
        end
    end

    assign pin_req = s_q.req;
endmodule : ext_pin_detect
`default_nettype wire

// ==== design/four_level_vectored_irq_ctrl.sv ====
// Vectored interrupt controller: 13 sources in 15 ranks, four priority levels.
// Assumes the execution unit pulses cpu_ack when it takes the vector
// and irq_return_instr when the return instruction executes.
`default_nettype none
// Contract
// (RQ1) Every request latched into a pending flag
// (RQ2) Priority level is high bit, low bit
// (RQ3) Only strictly higher level pre-empts service
// (RQ4) Highest pending level granted first
// (RQ5) Ties resolved by fixed polling rank
// (RQ6) Vector is 0x0003 plus eight times rank
// (RQ7) Hardware clears edge and timer flags
// (RQ8) Unit finishes instruction, pushes, loads vector
// (RQ9) Return releases the active service level
// (RQ10) Two enable, four priority 8-bit registers
// (RQ11) Settings writable anytime, effective immediately
// (RQ12) Pins low-level or falling-edge per select
// (RQ13) Global enable gates all sources
// (RQ14) Pins sampled once per peripheral cycle
// (RQ15) Track in-service levels for nested unwind
// (RQ16) Reserved slots never raise requests
module four_level_vectored_irq_ctrl (
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        cfg_wr,
    input  wire logic [2:0]  cfg_sel,
    input  wire logic [7:0]  cfg_wdata,
    input  wire logic        ext_irq_pin_a,
    input  wire logic        ext_irq_pin_b,
    input  wire logic [1:0]  ext_trigger_select,
    input  wire logic        timer0_ovf,
    input  wire logic        timer1_ovf,
    input  wire logic        serial_irq,
    input  wire logic        decoder_irq,
    input  wire logic        audio_irq,
    input  wire logic        card_irq,
    input  wire logic        twowire_irq,
    input  wire logic        spi_irq,
    input  wire logic        adc_irq,
    input  wire logic        usb_irq,
    input  wire logic [3:0]  key_matrix_irq_in,
    input  wire logic [14:0] sw_flag_clear,
    input  wire logic        cpu_ack,
    input  wire logic        irq_return_instr,
    output logic      [7:0]  irq_enable_reg_a,
    output logic      [7:0]  irq_enable_reg_b,
    output logic      [7:0]  prio_high_reg_a,
    output logic      [7:0]  prio_high_reg_b,
    output logic      [7:0]  prio_low_reg_a,
    output logic      [7:0]  prio_low_reg_b,
    output logic      [14:0] pending_flags,
    output logic      [3:0]  in_service_levels,
    output logic             irq_request,
    output logic      [15:0] irq_vector,
    output logic      [1:0]  irq_level,
    output logic      [3:0]  irq_source
);
    typedef struct packed {
        logic [7:0]  ena;
        logic [7:0]  enb;
        logic [7:0]  pha;
        logic [7:0]  phb;
        logic [7:0]  pla;
        logic [7:0]  plb;
        logic [14:0] pend;
        logic [3:0]  isv;
        logic        req;
        logic [15:0] vec;
        logic [1:0]  lvl;
        logic [3:0]  src;
        logic [2:0]  div;
    } ctrl_s;

    ctrl_s s_q;
    ctrl_s s_d;

    logic        sample_en;
    logic [1:0]  pin_req;
    logic [14:0] src_set;
    logic [14:0] elig;
    logic [14:0] ph_all;
    logic [14:0] pl_all;
    logic        found;
    logic [1:0]  best_lvl;
    logic [3:0]  best_src;
    logic        isv_any;
    logic [1:0]  isv_top;
    logic        grant_ok;
    logic        ack_ok;

    assign sample_en = (s_q.div == irq_ctrl_pkg::SAMPLE_LAST); // [RQ14]

    ext_pin_detect u_pins (
        .ref_clk            (ref_clk),
        .sys_rst            (sys_rst),
        .sample_en          (sample_en),
        .pin_n              ({ext_irq_pin_b, ext_irq_pin_a}),
        .ext_trigger_select (ext_trigger_select),
        .pin_req            (pin_req)
    );

    always_comb begin
        src_set = {1'b0, usb_irq, 1'b0,
                   sample_en & (|key_matrix_irq_in),
                   adc_irq, spi_irq, twowire_irq, card_irq, audio_irq,
                   decoder_irq, serial_irq, timer1_ovf, pin_req[1],
                   timer0_ovf, pin_req[0]}; // [RQ1]
        ph_all = {s_q.phb, s_q.pha[6:0]};
        pl_all = {s_q.plb, s_q.pla[6:0]};
        elig = s_q.pend & {s_q.enb, s_q.ena[6:0]} & ~irq_ctrl_pkg::RSVD_MASK
             & {15{s_q.ena[irq_ctrl_pkg::GLOBAL_EN_BIT]}}; // [RQ13] [RQ16]
        found = 1'b0;
        best_lvl = 2'h0;
        best_src = 4'h0;
        for (int r = 14; r >= 0; r--) begin
            // Descending scan: lower rank overwrites on a tie [RQ5]
            if (elig[r] && (!found || {ph_all[r], pl_all[r]} >= best_lvl))
            begin
                found = 1'b1;
                best_lvl = {ph_all[r], pl_all[r]}; // [RQ2] [RQ4]
                best_src = 4'(r);
            end
        end
        isv_any = |s_q.isv;
        isv_top = 2'h0;
        for (int l = 0; l < 4; l++) begin
            if (s_q.isv[l]) begin
                isv_top = 2'(l);
            end
        end
        grant_ok = found && (!isv_any || best_lvl > isv_top); // [RQ3]
        ack_ok = cpu_ack && s_q.req; // [RQ8]
    end

    always_comb begin
        s_d = s_q;
        s_d.div = sample_en ? 3'h0 : s_q.div + 3'h1;
        if (cfg_wr) begin // [RQ10] [RQ11]
            case (cfg_sel)
                irq_ctrl_pkg::SEL_EN_A: s_d.ena = cfg_wdata
                                        & irq_ctrl_pkg::REG_A_MASK;
                irq_ctrl_pkg::SEL_EN_B: s_d.enb = cfg_wdata
                                        & irq_ctrl_pkg::REG_B_MASK;
                irq_ctrl_pkg::SEL_PH_A: s_d.pha = cfg_wdata
                                        & irq_ctrl_pkg::PRIO_A_MASK;
                irq_ctrl_pkg::SEL_PH_B: s_d.phb = cfg_wdata
                                        & irq_ctrl_pkg::REG_B_MASK;
                irq_ctrl_pkg::SEL_PL_A: s_d.pla = cfg_wdata
                                        & irq_ctrl_pkg::PRIO_A_MASK;
                irq_ctrl_pkg::SEL_PL_B: s_d.plb = cfg_wdata
                                        & irq_ctrl_pkg::REG_B_MASK;
                default: s_d.ena = s_q.ena;
            endcase
        end
        // Hardware clear on vectoring, software clear, set wins [RQ7]
        s_d.pend = s_q.pend & ~sw_flag_clear;
        if (ack_ok && (irq_ctrl_pkg::TIMER_MASK[s_q.src] ||
            (s_q.src == irq_ctrl_pkg::SRC_EXT_A && ext_trigger_select[0]) ||
            (s_q.src == irq_ctrl_pkg::SRC_EXT_B && ext_trigger_select[1])))
        begin
            s_d.pend[s_q.src] = 1'b0; // [RQ7]
        end
        s_d.pend = (s_d.pend | src_set) & ~irq_ctrl_pkg::RSVD_MASK; // [RQ1]
        // Return releases the top level, then a taken grant enters service
        if (irq_return_instr && isv_any) begin
            s_d.isv[isv_top] = 1'b0; // [RQ9] [RQ15]
        end
        if (ack_ok) begin
            s_d.isv[s_q.lvl] = 1'b1; // [RQ15]
        end
        s_d.req = grant_ok && !ack_ok;
        s_d.lvl = best_lvl;
        s_d.src = best_src;
        s_d.vec = irq_ctrl_pkg::VEC_BASE
                + 16'({best_src, 3'h0}); // [RQ6]
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign irq_enable_reg_a  = s_q.ena;
    assign irq_enable_reg_b  = s_q.enb;
    assign prio_high_reg_a   = s_q.pha;
    assign prio_high_reg_b   = s_q.phb;
    assign prio_low_reg_a    = s_q.pla;
    assign prio_low_reg_b    = s_q.plb;
    assign pending_flags     = s_q.pend;
    assign in_service_levels = s_q.isv;
    assign irq_request       = s_q.req;
    assign irq_vector        = s_q.vec;
    assign irq_level         = s_q.lvl;
    assign irq_source        = s_q.src;

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    property p_capture;
        timer0_ovf |=> pending_flags[1];
    endproperty
    a_capture: assert property (p_capture) // [RQ1]
        else $error("timer request not captured");

    property p_level_map;
        irq_request && !$past(cfg_wr) |->
            irq_level == {ph_all[irq_source], pl_all[irq_source]};
    endproperty
    a_level_map: assert property (p_level_map) // [RQ2]
        else $error("granted level does not match priority bits");

    property p_preempt;
        irq_request |-> !$past(isv_any) || irq_level > $past(isv_top);
    endproperty
    a_preempt: assert property (p_preempt) // [RQ3]
        else $error("grant not above level in service");

    property p_highest;
        found && grant_ok && !ack_ok |=>
            irq_request && irq_level == $past(best_lvl);
    endproperty
    a_highest: assert property (p_highest) // [RQ4]
        else $error("highest pending level not granted");

    property p_vector;
        irq_request |-> irq_vector == irq_ctrl_pkg::VEC_BASE
                       + 16'({irq_source, 3'h0});
    endproperty
    a_vector: assert property (p_vector) // [RQ6]
        else $error("vector address wrong");

    property p_hw_clear;
        cpu_ack && irq_request && irq_source == 4'h1 && !timer0_ovf
            |=> !pending_flags[1];
    endproperty
    a_hw_clear: assert property (p_hw_clear) // [RQ7]
        else $error("timer flag not cleared on vectoring");

    property p_enter;
        cpu_ack && irq_request |=> in_service_levels[$past(irq_level)]
                                  && !irq_request;
    endproperty
    a_enter: assert property (p_enter) // [RQ15]
        else $error("acknowledged level not in service");

    property p_return;
        irq_return_instr && !cpu_ack && in_service_levels != 4'h0 |=>
            $countones(in_service_levels)
                == $countones($past(in_service_levels)) - 1;
    endproperty
    a_return: assert property (p_return) // [RQ9]
        else $error("return did not release a level");

    property p_global;
        !irq_enable_reg_a[irq_ctrl_pkg::GLOBAL_EN_BIT] |=> !irq_request;
    endproperty
    a_global: assert property (p_global) // [RQ13]
        else $error("request granted while globally disabled");

    property p_reserved;
        !pending_flags[12] && !pending_flags[14];
    endproperty
    a_reserved: assert property (p_reserved) // [RQ16]
        else $error("reserved slot pending");

    property p_cfg;
        cfg_wr && cfg_sel == irq_ctrl_pkg::SEL_EN_A |=>
            irq_enable_reg_a == $past(cfg_wdata);
    endproperty
    a_cfg: assert property (p_cfg) // [RQ11]
        else $error("enable write not taken");

    property p_sample;
        sample_en |=> !sample_en [*5] ##1 sample_en;
    endproperty
    a_sample: assert property (p_sample) // [RQ14]
        else $error("sample period wrong");

    c_grant: cover property (cpu_ack && irq_request);
    c_nested: cover property ($countones(in_service_levels) == 2);
    c_return: cover property (irq_return_instr && in_service_levels != 4'h0);
endmodule : four_level_vectored_irq_ctrl
`default_nettype wire

// ==== design/irq_ctrl_pkg.sv ====
// Shared constants for the four-level vectored interrupt controller.
// Assumes a single 100 MHz core clock; peripheral clock equals core clock.
`default_nettype none
package irq_ctrl_pkg;
    localparam int unsigned NSRC = 15;
    // Configuration write selects
    localparam logic [2:0] SEL_EN_A = 3'h0;
    localparam logic [2:0] SEL_EN_B = 3'h1;
    localparam logic [2:0] SEL_PH_A = 3'h2;
    localparam logic [2:0] SEL_PH_B = 3'h3;
    localparam logic [2:0] SEL_PL_A = 3'h4;
    localparam logic [2:0] SEL_PL_B = 3'h5;
    // Field positions and masks
    localparam int unsigned GLOBAL_EN_BIT = 7;
    localparam logic [7:0] REG_A_MASK = 8'hff;
    localparam logic [7:0] PRIO_A_MASK = 8'h7f;
    localparam logic [7:0] REG_B_MASK = 8'h5f;
    localparam logic [14:0] RSVD_MASK = 15'h5000;
    localparam logic [14:0] TIMER_MASK = 15'h000a;
    localparam logic [14:0] EXT_MASK = 15'h0005;
    localparam logic [7:0] REG_RST = 8'h00;
    // Source ranks
    localparam logic [3:0] SRC_EXT_A = 4'h0;
    localparam logic [3:0] SRC_EXT_B = 4'h2;
    // Vectors
    localparam logic [15:0] VEC_BASE = 16'h0003;
    localparam int unsigned VEC_SHIFT = 3;
    // Sampling: one peripheral cycle of 6 peripheral clock periods
    localparam int unsigned PERIPH_CYCLE_PCLK = 6;
    localparam int unsigned PCLK_PER_REF = 1;
    localparam logic [2:0] SAMPLE_LAST =
        3'(PERIPH_CYCLE_PCLK * PCLK_PER_REF - 1);
endpackage : irq_ctrl_pkg
`default_nettype wire

// ==== tb/exec_unit_model.sv ====
// Execution unit model: takes grants, issues return pulses.
// Assumes the controller's grant handshake on ref_clk.
`default_nettype none
module exec_unit_model (
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    input  wire logic       irq_request,
    input  wire logic [1:0] ack_dly,
    input  wire logic       ret_cmd,
    output logic            cpu_ack,
    output logic            irq_return_instr
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] wait_q;
    always @(posedge ref_clk) begin
        cpu_ack <= 1'b0;
        wait_q <= 2'h0;
        // Return instruction on command
        irq_return_instr <= ret_cmd & ~sys_rst;
        if (!sys_rst && irq_request && !cpu_ack) begin
            // Finish the instruction, push, load vector
            if (wait_q >= ack_dly) begin
                cpu_ack <= 1'b1;
            end else begin
                wait_q <= wait_q + 2'h1;
            end
        end
    end
endmodule : exec_unit_model
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the vectored interrupt controller.
// Assumes the execution unit model answers grants.
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
    err_count++; $display("CHECK FAILED t=%0t got %h exp %h", \
    $time, g, e); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic            ref_clk = 1'b0, sys_rst = 1'b1, cfg_wr = 1'b0;
    logic            ext_irq_pin_a = 1'b1, ext_irq_pin_b = 1'b1;
    logic            ret_cmd = 1'b0;
    logic [2:0]      cfg_sel = 3'h0;
    logic [7:0]      cfg_wdata = 8'h00, rnd = 8'h5d;
    logic [1:0]      ext_trigger_select = 2'h0, ack_dly = 2'h0;
    logic [9:0]      per = 10'h000;
    logic [3:0]      key_matrix_irq_in = 4'h0;
    logic [14:0]     sw_flag_clear = 15'h0000;
    logic [5:0][7:0] exp_rb = '0;
    logic [5:0][7:0] msk = {8'h5f, 8'h7f, 8'h5f, 8'h7f, 8'h5f, 8'hff};
    wire             cpu_ack, irq_return_instr, irq_request;
    wire  [5:0][7:0] rb;
    wire  [14:0]     pend;
    wire  [3:0]      ins, src;
    wire  [15:0]     vec;
    wire  [1:0]      lvl;
    int              err_count = 0, checks_done = 0, i;
    logic [21:0]     exp_q[$];
    logic [21:0]     exp_v;
    byte             rk[11] = '{1, 3, 4, 5, 6, 7, 8, 9, 10, 11, 13};

    four_level_vectored_irq_ctrl four_level_vectored_irq_ctrl_inst (
        .ref_clk, .sys_rst, .cfg_wr, .cfg_sel, .cfg_wdata,
        .ext_irq_pin_a, .ext_irq_pin_b, .ext_trigger_select,
        .timer0_ovf(per[0]), .timer1_ovf(per[1]), .serial_irq(per[2]),
        .decoder_irq(per[3]), .audio_irq(per[4]), .card_irq(per[5]),
        .twowire_irq(per[6]), .spi_irq(per[7]), .adc_irq(per[8]),
        .usb_irq(per[9]), .key_matrix_irq_in, .sw_flag_clear,
        .cpu_ack, .irq_return_instr,
        .irq_enable_reg_a(rb[0]), .irq_enable_reg_b(rb[1]),
        .prio_high_reg_a(rb[2]), .prio_high_reg_b(rb[3]),
        .prio_low_reg_a(rb[4]), .prio_low_reg_b(rb[5]),
        .pending_flags(pend), .in_service_levels(ins), .irq_request,
        .irq_vector(vec), .irq_level(lvl), .irq_source(src)
    );
    exec_unit_model exec_unit_model_inst (
        .ref_clk, .sys_rst, .irq_request, .ack_dly, .ret_cmd,
        .cpu_ack, .irq_return_instr
    );

    always #5 ref_clk = ~ref_clk;

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : cyc
    task automatic wr(input logic [2:0] s, input logic [7:0] d);
        cfg_sel = s;
        cfg_wdata = d;
        cfg_wr = 1'b1;
        cyc(1);
        cfg_wr = 1'b0;
        cyc(1);
    endtask : wr
    task automatic note(input logic [3:0] r, input logic [1:0] l);
        exp_q.push_back({16'h0003 + 16'(r) * 16'h0008, l, r});
    endtask : note
    task automatic wait_is(input logic [3:0] v);
        for (int n = 0; n < 300 && ins !== v; n++) cyc(1);
        if (ins !== v) begin
            err_count++;
            $display("CHECK FAILED t=%0t wait timeout", $time);
            tally_and_finish();
        end
    endtask : wait_is
    task automatic svc_end(input int r);
        sw_flag_clear = 15'(1) << r;
        cyc(1);
        sw_flag_clear = 15'h0000;
        ret_cmd = 1'b1;
        cyc(1);
        ret_cmd = 1'b0;
        cyc(1);
    endtask : svc_end
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : tally_and_finish

    // Grant monitor: each taken vector against oldest note
    always @(posedge ref_clk) begin
        if (!sys_rst && cpu_ack === 1'b1 && irq_request === 1'b1) begin
            if (exp_q.size() == 0) `CHK(1'b1, 1'b0)
            else begin
                exp_v = exp_q.pop_front();
                `CHK({vec, lvl, src}, exp_v)
            end
        end
    end

    initial begin
        cyc(12);
        sys_rst = 1'b0;
        // Random writes, selects 6 and 7 ignored
        for (i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            wr(3'(i), rnd);
            if (i < 6) exp_rb[i] = rnd & msk[i];
            `CHK(rb, exp_rb)
        end
        sys_rst = 1'b1;
        cyc(2);
        sys_rst = 1'b0;
        `CHK({rb, pend, ins, irq_request}, 68'h0)
        // Global enable off blocks grant
        ack_dly = 2'h3;
        wr(3'h0, 8'h02);
        per[0] = 1'b1;
        cyc(1);
        per[0] = 1'b0;
        cyc(8);
        `CHK(irq_request, 1'b0)
        `CHK(pend[1], 1'b1)
        note(0, 0);
        exp_q.delete();
        note(1, 0);
        wr(3'h0, 8'h82);
        wait_is(4'h1);
        `CHK(pend[1], 1'b0)
        svc_end(1);
        wait_is(4'h0);
        // Edge pin a held 8 cycles, level pin b
        ack_dly = 2'h0;
        ext_trigger_select = 2'b01;
        wr(3'h0, 8'h85);
        note(0, 0);
        ext_irq_pin_a = 1'b0;
        cyc(8);
        ext_irq_pin_a = 1'b1;
        wait_is(4'h1);
        `CHK(pend[0], 1'b0)
        svc_end(0);
        note(2, 0);
        ext_irq_pin_b = 1'b0;
        cyc(12);
        wait_is(4'h1);
        `CHK(pend[2], 1'b1)
        ext_irq_pin_b = 1'b1;
        cyc(12);
        svc_end(2);
        wait_is(4'h0);
        // Edge pin b held 8 cycles
        ext_trigger_select = 2'b11;
        note(2, 0);
        ext_irq_pin_b = 1'b0;
        cyc(8);
        ext_irq_pin_b = 1'b1;
        wait_is(4'h1);
        `CHK(pend[2], 1'b0)
        svc_end(2);
        wait_is(4'h0);
        // All sources except the two pins at level 0 at once
        wr(3'h0, 8'hff);
        wr(3'h1, 8'hff);
        for (i = 0; i < 11; i++) note(4'(rk[i]), 0);
        per = 10'h3ff;
        key_matrix_irq_in = 4'h5;
        cyc(7);
        per = 10'h000;
        key_matrix_irq_in = 4'h0;
        `CHK(pend & 15'h5000, 15'h0000)
        for (i = 0; i < 11; i++) begin
            rnd = lfsr(rnd);
            ack_dly = rnd[1:0];
            wait_is(4'h1);
            svc_end(rk[i]);
        end
        wait_is(4'h0);
        // Nesting over levels 0 to 3
        ack_dly = 2'h1;
        wr(3'h0, 8'hb0);
        wr(3'h1, 8'h0c);
        wr(3'h3, 8'h0c);
        wr(3'h4, 8'h20);
        wr(3'h5, 8'h08);
        note(4, 0);
        per[2] = 1'b1;
        cyc(1);
        per[2] = 1'b0;
        wait_is(4'h1);
        `CHK(pend[4], 1'b1)
        note(5, 1);
        per[3] = 1'b1;
        cyc(1);
        per[3] = 1'b0;
        wait_is(4'h3);
        note(10, 3);
        note(9, 2);
        per[8:7] = 2'b11;
        cyc(1);
        per[8:7] = 2'b00;
        wait_is(4'hb);
        cyc(3);
        `CHK(irq_request, 1'b0)
        svc_end(10);
        wait_is(4'h7);
        svc_end(9);
        wait_is(4'h3);
        svc_end(5);
        wait_is(4'h1);
        svc_end(4);
        wait_is(4'h0);
        `CHK(exp_q.size(), 0)
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
